/* File: src/pixel_block_raster_ops_defines.vh */
// Register offsets, field positions, encodings and reset values of the pixel block engine
`ifndef PIXEL_BLOCK_RASTER_OPS_DEFINES_VH
`define PIXEL_BLOCK_RASTER_OPS_DEFINES_VH
`define REG_CONTROL 12'h000
`define REG_SRC_ADDR 12'h004
`define REG_SRC_PITCH 12'h008
`define REG_DST_ADDR 12'h00C
`define REG_DST_PITCH 12'h010
`define REG_EXTENT 12'h014
`define REG_BACKGROUND 12'h018
`define REG_FOREGROUND 12'h01C
`define REG_SRC_FACTOR 12'h020
`define REG_DST_FACTOR 12'h024
`define REG_START 12'h028
`define REG_STATUS 12'h02C
`define CTL_TRANSP_BIT 5
`define CTL_PP_LSB 10
`define CTL_PP_MSB 14
`define CTL_PSIZE_LSB 0
`define CTL_PSIZE_MSB 2
`define CTL_SRC_XY_BIT 16
`define CTL_DST_XY_BIT 17
`define CTL_EXPAND_BIT 18
`define CTL_FILL_BIT 19
`define PP_REPLACE 5'h00
`define PP_XOR 5'h0A
`define PP_SATURATING_SUBTRACT 5'h13
`define PP_MAX 5'h15
`define PP_MIN 5'h17
`define CONTROL_RESET 32'h0000_0000
`define PSIZE_RESET 3'h2
`endif

/* File: src/pixel_block_raster_ops.v */
// Pixel block transfer engine with transparency, colour expansion and pixel functions
`timescale 1ns/1ps
`include "pixel_block_raster_ops_defines.vh"
module pixel_block_raster_ops (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output wire busy
);
  localparam S_IDLE = 3'd0;
  localparam S_RD_SRC = 3'd1;
  localparam S_RD_DST = 3'd2;
  localparam S_WR_DST = 3'd3;
  localparam S_NEXT = 3'd4;

  reg [31:0] control;
  reg [31:0] src_addr;
  reg [31:0] src_pitch;
  reg [31:0] dst_addr;
  reg [31:0] dst_pitch;
  reg [31:0] extent;
  reg [31:0] background_colour;
  reg [31:0] foreground_colour;
  reg [31:0] source_pitch_factor;
  reg [31:0] dest_pitch_factor;
  reg [2:0] state;
  reg [15:0] col;
  reg [15:0] row;
  reg [31:0] src_pix;
  wire [31:0] dst_pix;
  reg [31:0] read_value;
  reg done;
  reg [31:0] result;
  reg [31:0] pix_mask;
  reg [5:0] pix_bits;
  reg [31:0] src_bit_addr;
  reg [31:0] dst_bit_addr;
  reg [31:0] src_row_start;
  reg [31:0] dst_row_start;
  reg [31:0] src_sel;
  reg [31:0] dst_sel;
  reg [31:0] merged;
  reg [31:0] src_x;
  reg [31:0] dst_x;
  wire [4:0] pp_code;
  wire transp_on;
  wire expand;
  wire fill;
  wire [2:0] psize;
  wire bus_wr;
  wire start_pulse;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign bus_wr = psel & penable & pwrite;
  assign start_pulse = bus_wr & (paddr == `REG_START) & (state == S_IDLE);
  assign pp_code = control[`CTL_PP_MSB:`CTL_PP_LSB];
  assign transp_on = control[`CTL_TRANSP_BIT];
  assign expand = control[`CTL_EXPAND_BIT];
  assign fill = control[`CTL_FILL_BIT];
  assign psize = control[`CTL_PSIZE_MSB:`CTL_PSIZE_LSB];
  assign busy = (state != S_IDLE);
  // Destination pixel straight from read data; a registered copy would be one pixel stale
  assign dst_pix = (mem_rdata >> dst_bit_addr[4:0]) & pix_mask;

  // Pixel width as 1 << psize, capped at 32 bits
  always @* begin
    pix_bits = (psize > 3'd5) ? 6'd32 : (6'd1 << psize);
    pix_mask = (pix_bits == 6'd32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << pix_bits) - 32'h0000_0001);
  end

  // Bit addresses: XY uses y*factor + x*pixel, linear adds row*pitch
  always @* begin
    src_x = {16'h0000, col};
    dst_x = {16'h0000, col};
    if (control[`CTL_SRC_XY_BIT] && !expand) begin
      src_row_start = (({16'h0000, src_addr[31:16]} + {16'h0000, row}) * source_pitch_factor)
        + ({16'h0000, src_addr[15:0]} << psize);
    end else begin
      src_row_start = src_addr + ({16'h0000, row} * src_pitch);
    end
    if (control[`CTL_DST_XY_BIT]) begin
      dst_row_start = (({16'h0000, dst_addr[31:16]} + {16'h0000, row}) * dest_pitch_factor)
        + ({16'h0000, dst_addr[15:0]} << psize);
    end else begin
      dst_row_start = dst_addr + ({16'h0000, row} * dst_pitch);
    end
    src_bit_addr = expand ? (src_row_start + src_x) : (src_row_start + (src_x << psize));
    dst_bit_addr = dst_row_start + (dst_x << psize);
  end

  // Pixel function; unsigned compare at the pixel width
  always @* begin
    src_sel = src_pix & pix_mask;
    dst_sel = dst_pix & pix_mask;
    case (pp_code)
      `PP_MAX: result = (src_sel > dst_sel) ? src_sel : dst_sel;
      `PP_MIN: result = (src_sel < dst_sel) ? src_sel : dst_sel;
      `PP_SATURATING_SUBTRACT: result = (dst_sel > src_sel) ? (dst_sel - src_sel) : 32'h0000_0000;
      `PP_XOR: result = src_sel ^ dst_sel;
      default: result = src_sel;
    endcase
    // Insert the result into the destination word at its bit offset
    merged = (mem_rdata & ~(pix_mask << dst_bit_addr[4:0]))
      | ((result & pix_mask) << dst_bit_addr[4:0]);
  end

  // APB register writes; software start only accepted while idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `CONTROL_RESET | {29'h0, `PSIZE_RESET};
      src_pitch <= 32'h0000_0000;
      dst_pitch <= 32'h0000_0000;
      extent <= 32'h0000_0000;
      background_colour <= 32'h0000_0000;
      foreground_colour <= 32'h0000_0000;
      source_pitch_factor <= 32'h0000_0000;
      dest_pitch_factor <= 32'h0000_0000;
    end else if (bus_wr) begin
      if (paddr == `REG_CONTROL) begin
        control <= pwdata;
      end else if (paddr == `REG_SRC_PITCH) begin
        src_pitch <= pwdata;
      end else if (paddr == `REG_DST_PITCH) begin
        dst_pitch <= pwdata;
      end else if (paddr == `REG_EXTENT) begin
        extent <= pwdata;
      end else if (paddr == `REG_BACKGROUND) begin
        background_colour <= pwdata;
      end else if (paddr == `REG_FOREGROUND) begin
        foreground_colour <= pwdata;
      end else if (paddr == `REG_SRC_FACTOR) begin
        source_pitch_factor <= pwdata;
      end else if (paddr == `REG_DST_FACTOR) begin
        dest_pitch_factor <= pwdata;
      end
    end
  end

  // APB read mux; unmapped reads give zero
  always @* begin
    if (paddr == `REG_CONTROL) begin
      read_value = control;
    end else if (paddr == `REG_SRC_ADDR) begin
      read_value = src_addr;
    end else if (paddr == `REG_SRC_PITCH) begin
      read_value = src_pitch;
    end else if (paddr == `REG_DST_ADDR) begin
      read_value = dst_addr;
    end else if (paddr == `REG_DST_PITCH) begin
      read_value = dst_pitch;
    end else if (paddr == `REG_EXTENT) begin
      read_value = extent;
    end else if (paddr == `REG_BACKGROUND) begin
      read_value = background_colour;
    end else if (paddr == `REG_FOREGROUND) begin
      read_value = foreground_colour;
    end else if (paddr == `REG_SRC_FACTOR) begin
      read_value = source_pitch_factor;
    end else if (paddr == `REG_DST_FACTOR) begin
      read_value = dest_pitch_factor;
    end else if (paddr == `REG_STATUS) begin
      read_value = {30'h0, done, busy};
    end else begin
      read_value = 32'h0000_0000;
    end
  end

  // Read data captured in the setup cycle, so it stands from a flop in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= read_value;
    end
  end

  // Transfer engine: read source, read destination, write merged word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      src_addr <= 32'h0000_0000;
      dst_addr <= 32'h0000_0000;
      col <= 16'h0000;
      row <= 16'h0000;
      src_pix <= 32'h0000_0000;
      done <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else begin
      case (state)
        S_IDLE: begin
          if (bus_wr && paddr == `REG_SRC_ADDR) begin
            src_addr <= pwdata;
          end
          if (bus_wr && paddr == `REG_DST_ADDR) begin
            dst_addr <= pwdata;
          end
          if (bus_wr && paddr == `REG_STATUS && pwdata[1]) begin
            done <= 1'b0;
          end
          if (start_pulse) begin
            col <= 16'h0000;
            row <= 16'h0000;
            done <= 1'b0;
            if (extent[15:0] == 16'h0000 || extent[31:16] == 16'h0000) begin
              done <= 1'b1;
            end else if (fill) begin
              src_pix <= foreground_colour; // Fill uses foreground as source
              state <= S_RD_DST;
            end else begin
              state <= S_RD_SRC;
            end
          end
        end
        S_RD_SRC: begin
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_addr <= {src_bit_addr[31:5], 5'h00};
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            if (expand) begin
              src_pix <= mem_rdata[src_bit_addr[4:0]] ? foreground_colour
                : background_colour;
            end else begin
              src_pix <= (mem_rdata >> src_bit_addr[4:0]) & pix_mask;
            end
            state <= S_RD_DST;
          end
        end
        S_RD_DST: begin
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_addr <= {dst_bit_addr[31:5], 5'h00};
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            // Merge sees this pixel's destination via the live read data
            if (transp_on && ((src_pix & pix_mask) == 32'h0000_0000)) begin
              state <= S_NEXT;
            end else begin
              state <= S_WR_DST;
              mem_wdata <= merged;
            end
          end
        end
        S_WR_DST: begin
          mem_req <= 1'b1;
          mem_we <= 1'b1;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= S_NEXT;
          end
        end
        default: begin
          // Step column, then row; addresses are left at the last row's start when done
          if (col + 16'h0001 < extent[15:0]) begin
            col <= col + 16'h0001;
            state <= fill ? S_RD_DST : S_RD_SRC;
          end else if (row + 16'h0001 < extent[31:16]) begin
            col <= 16'h0000;
            row <= row + 16'h0001;
            state <= fill ? S_RD_DST : S_RD_SRC;
          end else begin
            src_addr <= src_row_start;
            dst_addr <= dst_row_start;
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* File: tb/pixel_block_raster_ops_properties.sv */
// Port-level properties of the pixel block engine
`timescale 1ns/1ps
`include "pixel_block_raster_ops_defines.vh"
module pixel_block_raster_ops_properties (
  input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire mem_req, mem_we, mem_ack, busy,
  input wire [11:0] paddr,
  input wire [31:0] mem_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Start strobe as seen at the access edge
  wire start_wr = psel && penable && pwrite && (paddr == `REG_START);
  property p_start; start_wr && !busy |=> busy; endproperty
  a_start: assert property (p_start) else $error("engine did not start");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped");
  property p_drop; mem_req && mem_ack |=> !mem_req; endproperty
  a_drop: assert property (p_drop) else $error("request after ack");
  // A write always follows a destination read two edges earlier
  property p_rmw; $rose(mem_req) && mem_we |-> $past(mem_ack, 2) && !$past(mem_we, 2);
  endproperty
  a_rmw: assert property (p_rmw) else $error("write without read");
  property p_busy; mem_req |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("request while idle");
  property p_align; mem_req |-> mem_addr[4:0] == 5'h00; endproperty
  a_align: assert property (p_align) else $error("unaligned address");
  property p_apb; psel && penable |-> pready && !pslverr; endproperty
  a_apb: assert property (p_apb) else $error("bus answer wrong");
  property p_done; busy |-> ##[0:400] !busy; endproperty
  a_done: assert property (p_done) else $error("transfer hangs");
endmodule
bind pixel_block_raster_ops pixel_block_raster_ops_properties u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack), .busy(busy),
  .paddr(paddr), .mem_addr(mem_addr));

/* File: tb/pixel_mem_model.sv */
// Behavioural frame buffer and system memory
`timescale 1ns/1ps
module pixel_mem_model (
  input wire pclk,
  input wire presetn,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [3:0] lat,
  output reg mem_ack,
  output reg [31:0] mem_rdata
);
  reg [31:0] mem [0:255];
  reg [3:0] wait_cnt;
  // Answer after lat cycles; data churns when idle so stale reads show
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_cnt <= 4'h0;
    end else if (mem_req && !mem_ack && wait_cnt >= lat) begin
      mem_ack <= 1'b1;
      wait_cnt <= 4'h0;
      if (mem_we) begin
        mem[mem_addr[12:5]] <= mem_wdata;
      end else begin
        mem_rdata <= mem[mem_addr[12:5]];
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: tb/pixel_block_raster_ops_tb.sv */
// Self-checking bench for the pixel block engine
`timescale 1ns/1ps
`include "pixel_block_raster_ops_defines.vh"
module pixel_block_raster_ops_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [3:0] lat = 4'h0;
  reg [31:0] rd;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
  wire pready, pslverr, mem_req, mem_we, mem_ack, busy;
  integer n_fail = 0, num_checks = 0, i;
  // Bus clock
  always #4 pclk = ~pclk;
  pixel_block_raster_ops u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy(busy));
  pixel_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task report_and_stop;
    begin
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // One APB transfer; request held until pready is sampled
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task blt(input [31:0] ctl, input [31:0] da, input [31:0] ext);
    begin
      apb(1'b1, `REG_CONTROL, ctl);
      apb(1'b1, `REG_SRC_ADDR, 32'h0000_0000);
      apb(1'b1, `REG_DST_ADDR, da);
      apb(1'b1, `REG_EXTENT, ext);
      apb(1'b1, `REG_START, 32'h0000_0000);
      @(posedge pclk);
      for (i = 0; busy !== 1'b0 && i < 500; i = i + 1) @(posedge pclk);
      chk("idle", 32'h0000_0000, {31'h0000_0000, busy});
    end
  endtask
  // Single 4-bit pixel; neighbours in the word must survive
  task px(input [4:0] f, input t, input [3:0] s, input [3:0] d, input [3:0] e);
    begin
      u_mem.mem[0] = {28'h000_0000, s};
      u_mem.mem[8] = {28'h765_4321, d};
      blt({17'h0_0000, f, 4'h0, t, 5'h02}, 32'h0000_0100, 32'h0001_0001);
      chk("pixel", {28'h765_4321, e}, u_mem.mem[8]);
    end
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #300000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `REG_CONTROL, 32'h0000_0000);
    chk("control", 32'h0000_0002, rd);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    apb(1'b1, `REG_SRC_PITCH, 32'h0000_0020);
    apb(1'b1, `REG_DST_PITCH, 32'h0000_0040);
    apb(1'b1, `REG_DST_FACTOR, 32'h0000_0100);
    apb(1'b1, `REG_SRC_FACTOR, 32'h0000_0080);
    apb(1'b1, `REG_BACKGROUND, 32'h3333_3333);
    apb(1'b1, `REG_FOREGROUND, 32'hAAAA_AAAA);
    px(`PP_MAX, 1'b0, 4'h2, 4'h1, 4'h2);
    px(`PP_MAX, 1'b0, 4'h2, 4'h6, 4'h6);
    px(`PP_MAX, 1'b0, 4'hF, 4'h7, 4'hF);
    px(`PP_MIN, 1'b0, 4'h2, 4'h6, 4'h2);
    lat <= 4'h3;
    px(`PP_SATURATING_SUBTRACT, 1'b0, 4'h2, 4'h1, 4'h0);
    px(`PP_SATURATING_SUBTRACT, 1'b0, 4'h2, 4'h6, 4'h4);
    px(`PP_XOR, 1'b0, 4'h2, 4'h1, 4'h3);
    px(`PP_XOR, 1'b0, 4'h2, 4'h6, 4'h4);
    px(`PP_REPLACE, 1'b0, 4'h9, 4'h5, 4'h9);
    px(`PP_MIN, 1'b1, 4'h0, 4'h5, 4'h5);
    px(`PP_REPLACE, 1'b1, 4'h9, 4'h5, 4'h9);
    px(`PP_REPLACE, 1'b0, 4'h0, 4'h5, 4'h0);
    lat <= 4'h0;
    u_mem.mem[0] = 32'h0000_0001;
    u_mem.mem[8] = 32'h5555_5555;
    blt(32'h0004_0002, 32'h0000_0100, 32'h0001_0002);
    chk("expand", 32'h5555_553A, u_mem.mem[8]);
    u_mem.mem[8] = 32'h5555_5555;
    blt(32'h0008_2802, 32'h0000_0100, 32'h0001_0001);
    chk("fill", 32'h5555_555F, u_mem.mem[8]);
    u_mem.mem[1] = 32'h0000_0007;
    u_mem.mem[10] = 32'h0000_0000;
    blt(32'h0000_0002, 32'h0000_0100, 32'h0002_0001);
    chk("row1", 32'h0000_0007, u_mem.mem[10]);
    apb(1'b0, `REG_DST_ADDR, 32'h0000_0000);
    chk("dst_addr", 32'h0000_0140, rd);
    u_mem.mem[0] = 32'h0000_0006;
    u_mem.mem[8] = 32'h0000_0000;
    blt(32'h0002_0002, 32'h0001_0002, 32'h0001_0001);
    chk("xy", 32'h0000_0600, u_mem.mem[8]);
    u_mem.mem[4] = 32'h0000_0009;
    u_mem.mem[10] = 32'h0000_0000;
    blt(32'h0001_0002, 32'h0000_0100, 32'h0002_0001);
    chk("src_xy", 32'h0000_0009, u_mem.mem[10]);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0002, rd & 32'h0000_0003);
    apb(1'b1, `REG_STATUS, 32'h0000_0002);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0000, rd & 32'h0000_0003);
    report_and_stop;
  end
endmodule
